// ---- include/serial_regs.vh ----
`ifndef SERIAL_REGS_VH
`define SERIAL_REGS_VH

// Register index within a channel window (address bits 2:0)
`define SP_REG_DATA      3'h0
`define SP_REG_STAT      3'h1
`define SP_REG_CTRL      3'h2
`define SP_REG_EXT       3'h3
`define SP_REG_DIV       3'h4
// Channel window 6 holds the interrupt registers
`define SP_GLOBAL_CH     3'h6
`define SP_REG_IRQ_STAT  3'h0
`define SP_REG_IRQ_MASK  3'h1

// Channel modes, control bits 1:0
`define SP_MODE_OFF      2'h0
`define SP_MODE_ASYNC    2'h1
`define SP_MODE_CLOCKED  2'h2
`define SP_MODE_HDLC     2'h3

// Control and extended register fields
`define SP_CTRL_CHAR7    2
`define SP_CTRL_NINTH    3
`define SP_CTRL_INTCLK   4
`define SP_CTRL_IRDA     5
`define SP_EXT_BRK_INH   1

// Transmit data word fields
`define SP_TXD_NINTH     8
`define SP_TXD_RAW       9

// Status register fields
`define SP_STAT_RXFULL   0
`define SP_STAT_TXBUSY   1
`define SP_STAT_BREAK    2
`define SP_STAT_OVERRUN  3

// Reset values
`define SP_CTRL_RST      8'h00
`define SP_CTRL_RST_ADC  8'h12
`define SP_EXT_RST       8'h00
`define SP_DIV_RST       8'h00

// Timing: last tick of a bit, mid-bit point, break length in ticks
`define SP_OS_LAST       3'h7
`define SP_OS_HALF       3'h3
`define SP_IRDA_PULSE    3'h2
`define SP_BRK_TICKS     7'h50
`define SP_STUFF_RUN     3'h5

`endif

// ---- src/char_rx.v ----
`include "serial_regs.vh"

module char_rx (
	input  wire       clk_sys,
	input  wire       reset,
	input  wire       os_tick,
	input  wire       smp_en,
	input  wire       sync_mode,
	input  wire       line,
	input  wire       char7,
	input  wire       ninth_en,
	input  wire       stuff_en,
	input  wire       brk_inh,
	output reg  [8:0] word,
	output reg        done,
	output reg        brk
);

	reg        act_r;
	reg        prev_r;
	reg        skip_r;
	reg  [2:0] cnt_r;
	reg  [3:0] idx_r;
	reg  [8:0] sh_r;
	reg  [2:0] ones_r;
	reg  [6:0] low_r;

	wire [3:0] need = (char7 ? 4'h7 : 4'h8) + {3'h0, ninth_en};
	wire [8:0] nsh  = {line, sh_r[8:1]};
	wire       hold = brk & brk_inh;

	// Right-justify the assembled bits; ninth bit goes to bit 8
	function [8:0] place;
		input [8:0] v;
		input [3:0] n;
		input       c7;
		input       ne;
		reg   [8:0] j;
		begin
			j     = v >> (4'h9 - n);
			place = c7 ? {ne & j[7], 1'b0, j[6:0]} : {ne & j[8], j[7:0]};
		end
	endfunction

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			word   <= 9'h000;
			done   <= 1'b0;
			brk    <= 1'b0;
			act_r  <= 1'b0;
			prev_r <= 1'b1;
			skip_r <= 1'b0;
			cnt_r  <= 3'h0;
			idx_r  <= 4'h0;
			sh_r   <= 9'h000;
			ones_r <= 3'h0;
			low_r  <= 7'h00;
		end else begin
			done <= 1'b0;
			if (os_tick) begin
				low_r  <= line ? 7'h00 : (low_r == `SP_BRK_TICKS ? low_r : low_r + 7'h01);
				prev_r <= line;
			end
			brk <= (low_r == `SP_BRK_TICKS) & ~line;
			if (sync_mode) begin
				act_r <= 1'b0;
				if (smp_en) begin
					if (skip_r) begin
						skip_r <= 1'b0;
						ones_r <= 3'h0;
					end else if (stuff_en && ones_r == `SP_STUFF_RUN) begin
						ones_r <= 3'h0;
						// Sixth one is a flag: realign and drop its closing zero
						if (line) begin
							idx_r  <= 4'h0;
							skip_r <= 1'b1;
						end
					end else begin
						sh_r   <= nsh;
						ones_r <= line ? ones_r + 3'h1 : 3'h0;
						if (idx_r == need - 4'h1) begin
							idx_r <= 4'h0;
							word  <= place(nsh, need, char7, ninth_en);
							done  <= 1'b1;
						end else begin
							idx_r <= idx_r + 4'h1;
						end
					end
				end
			end else if (os_tick) begin
				if (!act_r) begin
					if (prev_r && !line && !hold) begin
						act_r <= 1'b1;
						cnt_r <= `SP_OS_HALF;
						idx_r <= 4'h0;
					end
				end else if (hold) begin
					act_r <= 1'b0;
				end else if (cnt_r != 3'h0) begin
					cnt_r <= cnt_r - 3'h1;
				end else begin
					cnt_r <= `SP_OS_LAST;
					if (idx_r == 4'h0 && line) begin
						act_r <= 1'b0;
					end else if (idx_r == need + 4'h1) begin
						act_r <= 1'b0;
						// A low stop bit under inhibit belongs to a break
						if (line || !brk_inh) begin
							word <= place(sh_r, need, char7, ninth_en);
							done <= 1'b1;
						end
					end else begin
						if (idx_r != 4'h0)
							sh_r <= nsh;
						idx_r <= idx_r + 4'h1;
					end
				end
			end
		end
	end

endmodule

// ---- src/char_tx.v ----
`include "serial_regs.vh"

module char_tx (
	input  wire       clk_sys,
	input  wire       reset,
	input  wire       bit_en,
	input  wire       start,
	input  wire [8:0] word,
	input  wire       raw,
	input  wire       async_mode,
	input  wire       char7,
	input  wire       ninth_en,
	input  wire       stuff_en,
	output reg        line,
	output reg        busy,
	output reg        done
);

	reg  [10:0] sh_r;
	reg  [3:0]  left_r;
	reg  [2:0]  ones_r;
	reg         stuff_r;

	// Trailing ones past the character become stop bits
	wire        nine  = ninth_en ? word[8] : 1'b1;
	wire [8:0]  body  = char7 ? {1'b1, nine, word[6:0]} : {nine, word[7:0]};
	wire [3:0]  nbits = (char7 ? 4'h7 : 4'h8) + {3'h0, ninth_en} + (async_mode ? 4'h2 : 4'h0);

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			line    <= 1'b1;
			busy    <= 1'b0;
			done    <= 1'b0;
			sh_r    <= 11'h7ff;
			left_r  <= 4'h0;
			ones_r  <= 3'h0;
			stuff_r <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				if (start) begin
					busy    <= 1'b1;
					sh_r    <= async_mode ? {1'b1, body, 1'b0} : {2'b11, body};
					left_r  <= nbits;
					ones_r  <= 3'h0;
					stuff_r <= stuff_en & ~raw;
				end
			end else if (bit_en) begin
				if (stuff_r && ones_r == `SP_STUFF_RUN) begin
					line   <= 1'b0;
					ones_r <= 3'h0;
				end else if (left_r == 4'h0) begin
					busy <= 1'b0;
					done <= 1'b1;
					line <= 1'b1;
				end else begin
					line   <= sh_r[0];
					sh_r   <= {1'b1, sh_r[10:1]};
					left_r <= left_r - 4'h1;
					ones_r <= sh_r[0] ? ones_r + 3'h1 : 3'h0;
				end
			end
		end
	end

endmodule

// ---- src/six_serial_ports.v ----
`include "serial_regs.vh"

// Operation
// - Six independent channels, each async capable.
// - Async bit rate up to clock over eight.
// - Async character length of 7 or 8.
// - Optional ninth bit marks message first byte.
// - Clocked mode shifts data on clock line.
// - Ports C, D drive their clocks automatically.
// - Ports E, F add HDLC and infrared encoding.
// - Low receive input is detected as break.
// - Extended bit 1 inhibits assembly in break (async mode only).
// - Analogue variant: port B clocked for converter.
module six_serial_ports #(
	parameter ANALOG_VARIANT = 1,
	parameter NCH            = 6
) (
	input  wire        clk_sys,
	input  wire        reset,
	input  wire [5:0]  addr,
	input  wire [15:0] wr_data,
	input  wire        wr_en,
	input  wire        rd_en,
	output reg  [15:0] rd_data,
	output reg         irq,
	input  wire [5:0]  rxd,
	output wire [5:0]  txd,
	input  wire [5:0]  sclk_in,
	output wire [5:0]  sclk_out,
	output wire [5:0]  sclk_oe,
	output reg         converter_en
);

	wire [2:0]  ch_sel  = addr[5:3];
	wire [2:0]  reg_sel = addr[2:0];
	wire        gsel    = ch_sel == `SP_GLOBAL_CH;

	wire [16*NCH-1:0] rd_flat;
	wire [NCH-1:0]    rx_ev;
	wire [NCH-1:0]    tx_ev;
	wire [NCH-1:0]    clk_mode;

	reg  [11:0] ist_r;
	reg  [11:0] imask_r;

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch = ch + 1) begin : chan
			localparam [31:0] CHW     = ch;
			localparam [2:0]  CH      = CHW[2:0];
			localparam       CAN_CLK  = (ch < 4) ? 1'b1 : 1'b0;
			localparam       CAN_HDLC = (ch >= 4) ? 1'b1 : 1'b0;
			localparam       AUTO_CK  = (ch == 2 || ch == 3) ? 1'b1 : 1'b0;
			localparam [7:0] CTRL_INI = (ch == 1 && ANALOG_VARIANT != 0) ? `SP_CTRL_RST_ADC : `SP_CTRL_RST;

			reg  [7:0] ctrl_r;
			reg  [7:0] ext_r;
			reg  [7:0] div_r;
			reg  [7:0] dcnt_r;
			reg  [2:0] pcnt_r;
			reg  [8:0] rxbuf_r;
			reg        rxfull_r;
			reg        ovr_r;
			reg        start_r;
			reg  [9:0] txw_r;
			reg        rx1_r;
			reg        rx2_r;
			reg        ck1_r;
			reg        ck2_r;
			reg        ck3_r;
			reg        seen_r;
			reg        txpin_r;
			reg        sclk_r;
			reg        sclk_oe_r;

			wire [1:0] mode     = ctrl_r[1:0];
			wire       is_off   = mode == `SP_MODE_OFF;
			wire       is_async = mode == `SP_MODE_ASYNC;
			wire       is_clk   = mode == `SP_MODE_CLOCKED;
			wire       is_hdlc  = mode == `SP_MODE_HDLC;
			wire       int_clk  = ctrl_r[`SP_CTRL_INTCLK] | AUTO_CK;
			wire       ext_clk  = is_clk & ~int_clk;
			wire       irda     = is_hdlc & ctrl_r[`SP_CTRL_IRDA];
			wire       os_tick  = (dcnt_r == 8'h00) & ~is_off;
			wire       ph_end   = os_tick & (pcnt_r == `SP_OS_LAST);
			wire       ph_mid   = os_tick & (pcnt_r == `SP_OS_HALF);
			wire       ck_rise  = ck2_r & ~ck3_r;
			wire       ck_fall  = ~ck2_r & ck3_r;
			wire       tx_bit   = ext_clk ? ck_fall : ph_end;
			wire       rx_smp   = ext_clk ? ck_rise : ph_mid;
			wire       rx_line  = is_off ? 1'b1 : (irda ? ~seen_r : rx2_r);
			wire       sel      = ch_sel == CH;
			wire       wr_dat   = wr_en & sel & (reg_sel == `SP_REG_DATA);
			wire       rd_dat   = rd_en & sel & (reg_sel == `SP_REG_DATA);
			wire [1:0] wmode    = wr_data[1:0];
			wire       mode_ok  = (wmode == `SP_MODE_OFF) | (wmode == `SP_MODE_ASYNC) |
			                      ((wmode == `SP_MODE_CLOCKED) & CAN_CLK) |
			                      ((wmode == `SP_MODE_HDLC) & CAN_HDLC);
			wire       tx_busy;
			wire       tx_line;
			wire       tx_done;
			wire       rx_done;
			wire       rx_brk;
			wire [8:0] rx_word;
			wire [7:0] ctrl_nxt = {wr_data[7:2], mode_ok ? wmode : `SP_MODE_OFF};
			wire       tx_take  = wr_dat & ~tx_busy & ~start_r;

			// Configuration registers; an illegal mode is stored as off
			always @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					ctrl_r <= CTRL_INI;
					ext_r  <= `SP_EXT_RST;
					div_r  <= `SP_DIV_RST;
				end else begin
					if (wr_en && sel && reg_sel == `SP_REG_CTRL)
						ctrl_r <= ctrl_nxt;
					if (wr_en && sel && reg_sel == `SP_REG_EXT)
						ext_r <= wr_data[7:0];
					if (wr_en && sel && reg_sel == `SP_REG_DIV)
						div_r <= wr_data[7:0];
				end
			end

			// Eight ticks per bit: divisor 0 gives clock over eight
			always @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					dcnt_r <= 8'h00;
					pcnt_r <= 3'h0;
				end else begin
					dcnt_r <= (os_tick || is_off) ? div_r : dcnt_r - 8'h01;
					if (os_tick)
						pcnt_r <= pcnt_r + 3'h1;
				end
			end

			// Clock pins reset to their idle high level so no false edge follows reset
			always @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					rx1_r  <= 1'b1;
					rx2_r  <= 1'b1;
					ck1_r  <= 1'b1;
					ck2_r  <= 1'b1;
					ck3_r  <= 1'b1;
					seen_r <= 1'b0;
				end else begin
					rx1_r  <= rxd[ch];
					rx2_r  <= rx1_r;
					ck1_r  <= sclk_in[ch];
					ck2_r  <= ck1_r;
					ck3_r  <= ck2_r;
					seen_r <= ph_end ? 1'b0 : (seen_r | rx2_r);
				end
			end

			// Unconfigured channels never start a transfer
			always @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					start_r <= 1'b0;
					txw_r   <= 10'h000;
				end else begin
					start_r <= tx_take & ~is_off;
					if (tx_take)
						txw_r <= wr_data[9:0];
				end
			end

			// A new character wins over a read in the same cycle
			always @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					rxbuf_r  <= 9'h000;
					rxfull_r <= 1'b0;
					ovr_r    <= 1'b0;
				end else begin
					if (rx_done)
						rxbuf_r <= rx_word;
					rxfull_r <= rx_done | (rxfull_r & ~rd_dat);
					ovr_r    <= (rx_done & rxfull_r & ~rd_dat) | (ovr_r & ~rd_dat);
				end
			end

			// Infrared: a zero is a short high pulse, a one is dark
			always @(posedge clk_sys or posedge reset) begin
				if (reset) begin
					txpin_r   <= 1'b1;
					sclk_r    <= 1'b1;
					sclk_oe_r <= 1'b0;
				end else begin
					txpin_r   <= irda ? (~tx_line & (pcnt_r < `SP_IRDA_PULSE)) : tx_line;
					sclk_r    <= pcnt_r[2];
					sclk_oe_r <= is_clk & int_clk;
				end
			end

			char_tx u_tx (
				.clk_sys    (clk_sys),
				.reset      (reset),
				.bit_en     (tx_bit),
				.start      (start_r),
				.word       (txw_r[8:0]),
				.raw        (txw_r[`SP_TXD_RAW]),
				.async_mode (is_async),
				.char7      (ctrl_r[`SP_CTRL_CHAR7]),
				.ninth_en   (ctrl_r[`SP_CTRL_NINTH]),
				.stuff_en   (is_hdlc),
				.line       (tx_line),
				.busy       (tx_busy),
				.done       (tx_done)
			);

			char_rx u_rx (
				.clk_sys   (clk_sys),
				.reset     (reset),
				.os_tick   (os_tick),
				.smp_en    (rx_smp),
				.sync_mode (~is_async),
				.line      (rx_line),
				.char7     (ctrl_r[`SP_CTRL_CHAR7]),
				.ninth_en  (ctrl_r[`SP_CTRL_NINTH]),
				.stuff_en  (is_hdlc),
				.brk_inh   (ext_r[`SP_EXT_BRK_INH] & is_async),
				.word      (rx_word),
				.done      (rx_done),
				.brk       (rx_brk)
			);

			reg  [15:0] rd_word;

			always @* begin
				case (reg_sel)
					`SP_REG_DATA: rd_word = {7'h00, rxbuf_r};
					`SP_REG_STAT: rd_word = {12'h000, ovr_r, rx_brk, tx_busy | start_r, rxfull_r};
					`SP_REG_CTRL: rd_word = {8'h00, ctrl_r};
					`SP_REG_EXT:  rd_word = {8'h00, ext_r};
					`SP_REG_DIV:  rd_word = {8'h00, div_r};
					default:      rd_word = 16'h0000;
				endcase
			end

			assign rd_flat[16*ch +: 16] = rd_word;
			assign rx_ev[ch]    = rx_done;
			assign tx_ev[ch]    = tx_done;
			assign clk_mode[ch] = is_clk;
			assign txd[ch]      = txpin_r;
			assign sclk_out[ch] = sclk_r;
			assign sclk_oe[ch]  = sclk_oe_r;
		end
	endgenerate

	wire [11:0] irq_clr = (wr_en && gsel && reg_sel == `SP_REG_IRQ_STAT) ? wr_data[11:0] : 12'h000;
	wire [6:0]  rd_base = {ch_sel, 4'h0};
	reg  [15:0] rd_data_nxt;

	// Idle cycles and unmapped windows read as zero
	always @* begin
		rd_data_nxt = 16'h0000;
		if (rd_en) begin
			case (ch_sel)
				`SP_GLOBAL_CH: begin
					case (reg_sel)
						`SP_REG_IRQ_STAT: rd_data_nxt = {4'h0, ist_r};
						`SP_REG_IRQ_MASK: rd_data_nxt = {4'h0, imask_r};
						default:          rd_data_nxt = 16'h0000;
					endcase
				end
				default: begin
					if (ch_sel < NCH)
						rd_data_nxt = rd_flat[rd_base +: 16];
				end
			endcase
		end
	end

	// A new event wins over a simultaneous clear
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ist_r   <= 12'h000;
			imask_r <= 12'h000;
		end else begin
			ist_r <= {tx_ev, rx_ev} | (ist_r & ~irq_clr);
			if (wr_en && gsel && reg_sel == `SP_REG_IRQ_MASK)
				imask_r <= wr_data[11:0];
		end
	end

	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			irq          <= 1'b0;
			rd_data      <= 16'h0000;
			converter_en <= 1'b0;
		end else begin
			irq          <= |(ist_r & imask_r);
			rd_data      <= rd_data_nxt;
			// Converter only works while port B stays clocked
			converter_en <= (ANALOG_VARIANT != 0) & clk_mode[1];
		end
	end

endmodule

// ---- test/serial_peer.sv ----
module serial_peer (
	input  wire logic [5:0] txd,
	input  wire logic       clk,
	output logic      [5:0] rxd,
	output logic      [5:0] sclk_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rxd = 6'h3F;
		sclk_in = 6'h3F;
	end
	// One bit is eight clocks at the fastest divider
	task automatic put(input int ch, input logic b, input int n);
		rxd[ch] <= b;
		repeat (n * 8) @(posedge clk);
	endtask
	task automatic send(input int ch, input logic [8:0] v, input int n);
		put(ch, 1'b0, 1);
		for (int i = 0; i < n; i++) put(ch, v[i], 1);
		put(ch, 1'b1, 1);
	endtask
	// Samples mid-bit; bit n of the result is the stop bit
	task automatic grab(input int ch, input int n, output logic [9:0] v);
		int t;
		t = 0;
		v = 10'h000;
		while (txd[ch] !== 1'b0 && t < 4000) begin
			@(posedge clk);
			t++;
		end
		repeat (4) @(posedge clk);
		for (int i = 0; i <= n; i++) begin
			repeat (8) @(posedge clk);
			v[i] = txd[ch];
		end
	endtask
	// Link clock runs only inside the frame
	task automatic clk8(input int ch, input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			rxd[ch] <= v[i];
			sclk_in[ch] <= 1'b0;
			repeat (4) @(posedge clk);
			sclk_in[ch] <= 1'b1;
			repeat (4) @(posedge clk);
		end
		rxd[ch] <= ~v[7];
	endtask
endmodule

// ---- test/six_serial_ports_asserts.sv ----
module six_serial_ports_asserts #(
	parameter ANALOG_VARIANT = 1,
	parameter NCH            = 6
) (
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic [5:0]  addr,
	input wire logic [15:0] wr_data,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [15:0] rd_data,
	input wire logic        irq,
	input wire logic [5:0]  rxd,
	input wire logic [5:0]  txd,
	input wire logic [5:0]  sclk_in,
	input wire logic [5:0]  sclk_out,
	input wire logic [5:0]  sclk_oe,
	input wire logic        converter_en
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0]  ctl_r [6];
	logic [11:0] msk_r;
	logic [5:0]  on_r;
	logic [1:0]  up_r;
	logic [5:0]  oe;
	logic [1:0]  wm;
	logic [1:0]  rm;
	logic        cv;
	logic        ok;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// Illegal mode for a channel is stored as off
	assign wm = ((wr_data[1:0] == 2'h3 && addr[5:3] < 3'h4) ||
		(wr_data[1:0] == 2'h2 && addr[5:3] > 3'h3)) ? 2'h0 : wr_data[1:0];
	assign rm = ctl_r[addr[5:3]][1:0];
	assign cv = ANALOG_VARIANT != 0 && ctl_r[1][1:0] == 2'h2;
	assign ok = up_r == 2'h3;
	always_comb begin
		for (int c = 0; c < 6; c++) oe[c] = ctl_r[c][1:0] == 2'h2 && (c == 2 || c == 3 || ctl_r[c][4]);
	end
	always @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int c = 0; c < 6; c++) ctl_r[c] <= 6'h00;
			ctl_r[1] <= (ANALOG_VARIANT != 0) ? 6'h12 : 6'h00;
			on_r <= (ANALOG_VARIANT != 0) ? 6'h02 : 6'h00;
			msk_r <= 12'h000;
			up_r <= 2'h0;
		end else begin
			if (!ok) up_r <= up_r + 2'h1;
			if (wr_en && addr[2:0] == 3'h2 && addr[5:3] < 3'h6) begin
				ctl_r[addr[5:3]] <= {wr_data[5:2], wm};
				on_r[addr[5:3]] <= on_r[addr[5:3]] | (wm != 2'h0);
			end
			if (wr_en && addr == 6'h31) msk_r <= wr_data[11:0];
		end
	end
	sequence s_rd(a);
		rd_en && addr == a;
	endsequence
	sequence s_ctl_rd;
		rd_en && addr[2:0] == 3'h2 && addr[5:3] < 3'h6;
	endsequence
	a_rd_idle: assert property (!$past(rd_en) |-> rd_data == 16'h0000)
		else $error("read data not zero outside a read");
	a_rd_unmapped: assert property (s_rd(6'h3F) |=> rd_data == 16'h0000)
		else $error("unmapped read not zero");
	a_ctrl_mode: assert property (s_ctl_rd |=> rd_data[1:0] == $past(rm))
		else $error("control mode readback wrong");
	a_mask_back: assert property (s_rd(6'h31) |=> rd_data == {4'h0, $past(msk_r)})
		else $error("mask readback wrong");
	a_irq_masked: assert property (ok && $past(msk_r) == 12'h000 && $past(msk_r, 2) == 12'h000 |-> !irq)
		else $error("interrupt with all events masked");
	a_clk_drive: assert property (ok && $stable(oe) && $past(oe, 2) == oe |-> sclk_oe == oe)
		else $error("clock output enable wrong");
	a_conv_follow: assert property (ok && $stable(cv) && $past(cv, 2) == cv |-> converter_en == cv)
		else $error("converter enable wrong");
	a_txd_quiet: assert property (ok |-> (txd | on_r) == 6'h3F)
		else $error("unused channel left idle level");
endmodule

// ---- test/six_serial_ports_test.sv ----
module six_serial_ports_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic [5:0]  addr = 6'h00;
	logic [15:0] wr_data = 16'h0000;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic [15:0] rd_data;
	logic [15:0] rv;
	logic        irq;
	logic        converter_en;
	logic [5:0]  rxd;
	logic [5:0]  txd;
	logic [5:0]  sclk_in;
	logic [5:0]  sclk_out;
	logic [5:0]  sclk_oe;
	logic [9:0]  fv;
	int          n_fail = 0;
	int          n_tests = 0;
	int          cyc = 0;
	six_serial_ports i_six_serial_ports (.clk_sys(clk_sys), .reset(reset), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .rxd(rxd), .txd(txd), .sclk_in(sclk_in),
		.sclk_out(sclk_out), .sclk_oe(sclk_oe), .converter_en(converter_en));
	serial_peer i_serial_peer (.clk(clk_sys), .txd(txd), .rxd(rxd), .sclk_in(sclk_in));
	always #20 clk_sys = ~clk_sys;
	task automatic end_of_test;
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [5:0] a);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		@(negedge clk_sys);
		rv = rd_data;
		@(posedge clk_sys);
	endtask
	task automatic t_reset;
		chk("txd", 16'h003F, {10'h000, txd});
		rd(6'h0A);
		chk("ctrl b", 16'h0012, rv);
		rd(6'h02);
		chk("ctrl a", 16'h0000, rv);
		chk("conv", 16'h0001, {15'h0000, converter_en});
	endtask
	task automatic t_tx;
		wr(6'h02, 16'h0001);
		wr(6'h31, 16'h0040);
		wr(6'h00, 16'h00A5);
		i_serial_peer.grab(0, 8, fv);
		chk("frame", 16'h01A5, {6'h00, fv});
		repeat (12) @(posedge clk_sys);
		chk("irq on", 16'h0001, {15'h0000, irq});
		rd(6'h30);
		chk("irq stat", 16'h0042, rv);
		wr(6'h30, 16'h0040);
		repeat (2) @(posedge clk_sys);
		chk("irq off", 16'h0000, {15'h0000, irq});
	endtask
	task automatic t_rx;
		wr(6'h12, 16'h000D);
		i_serial_peer.send(2, 9'h0DA, 8);
		rd(6'h10);
		chk("rx 7+9", 16'h015A, rv);
	endtask
	task automatic t_brk;
		wr(6'h1A, 16'h0001);
		wr(6'h1B, 16'h0002);
		i_serial_peer.put(3, 1'b0, 12);
		rd(6'h19);
		chk("brk inh", 16'h0004, rv & 16'h0005);
		i_serial_peer.put(3, 1'b1, 2);
		wr(6'h22, 16'h0001);
		i_serial_peer.put(4, 1'b0, 12);
		i_serial_peer.put(4, 1'b1, 2);
		rd(6'h21);
		chk("brk full", 16'h0001, rv & 16'h0001);
		rd(6'h20);
		chk("brk data", 16'h0000, rv);
	endtask
	task automatic t_clk;
		int h;
		h = 0;
		wr(6'h02, 16'h0002);
		wr(6'h12, 16'h0002);
		i_serial_peer.clk8(0, 8'h3C);
		rd(6'h00);
		chk("clk rx", 16'h003C, rv);
		chk("oe", 16'h0004, {10'h000, sclk_oe} & 16'h003D);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			h += sclk_out[2];
		end
		chk("sclk high", 16'h0008, h[15:0]);
	endtask
	task automatic t_hdlc;
		wr(6'h22, 16'h0003);
		wr(6'h20, 16'h003E);
		i_serial_peer.grab(4, 8, fv);
		chk("hdlc stuff", 16'h011F, {6'h00, fv});
	endtask
	task automatic t_modes;
		wr(6'h2A, 16'h0002);
		rd(6'h2A);
		chk("f clk", 16'h0000, rv & 16'h0003);
		wr(6'h28, 16'h0055);
		rd(6'h29);
		chk("off busy", 16'h0000, rv & 16'h0002);
		wr(6'h2A, 16'h0023);
		rd(6'h2A);
		chk("f hdlc", 16'h0023, rv);
		chk("f irda idle", 16'h0000, {15'h0000, txd[5]});
		chk("f rclk in", 16'h0000, {15'h0000, sclk_oe[5]});
		wr(6'h02, 16'h0003);
		rd(6'h02);
		chk("a hdlc", 16'h0000, rv & 16'h0003);
		wr(6'h0A, 16'h0001);
		repeat (3) @(posedge clk_sys);
		chk("conv off", 16'h0000, {15'h0000, converter_en});
		rd(6'h3F);
		chk("unmapped", 16'h0000, rv);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		t_reset();
		t_tx();
		t_rx();
		t_brk();
		t_clk();
		t_hdlc();
		t_modes();
		end_of_test();
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
endmodule
bind six_serial_ports six_serial_ports_asserts #(.ANALOG_VARIANT(ANALOG_VARIANT), .NCH(NCH)) i_chk (
	.clk_sys(clk_sys), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
	.rd_data(rd_data), .irq(irq), .rxd(rxd), .txd(txd), .sclk_in(sclk_in), .sclk_out(sclk_out),
	.sclk_oe(sclk_oe), .converter_en(converter_en));
